/* File: prescaler.v */
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.vh"

// free divider: tick once every 2**sel clocks while running
module prescaler (
   input  wire                  clock_i,
   input  wire                  rst_n_i,
   input  wire                  run_i,
   input  wire [`PRE_SEL_W-1:0] sel_i,
   output wire                  tick_o
);
   reg  [`PRE_W-1:0] div_reg;
   wire [`PRE_W-1:0] div_mask;

   // mask of the low sel bits; tick when they are all ones, the divider itself wraps at 128
   assign div_mask = (`PRE_ONE << sel_i) - `PRE_ONE;
   assign tick_o   = run_i && ((div_reg & div_mask) == div_mask);

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_reg <= `PRE_ZERO;
      end else if (!run_i) begin
         // restart from zero so the first period is whole
         div_reg <= `PRE_ZERO;
      end else begin
         div_reg <= div_reg + `PRE_ONE;
      end
   end
endmodule
`default_nettype wire

/* File: reloadable_timer_core.v */
// Overview of operation
// - 16-bit counter steps up by one per qualified count event.
// - past ffff the count wraps to 0000 and keeps counting.
// - reload 0000 with prescale 128 gives the longest time-out.
// - reload 0001 with prescale 1 gives the shortest time-out.
// - one-shot: at reload, event, count to 0001, clear enable, stop.
// - one-shot with output enabled: output inverts for one clock.
// - one-shot, continuous and pwm count prescaled system clock ticks.
// - continuous: at reload, event, count to 0001, go on, toggle output.
// - written start count holds for first pass only; later passes 0001.
// - counter mode counts input edges, polarity picks rising or falling.
// - counter mode bypasses the prescaler.
// - counter: at reload, event, count to 0001, go on, toggle output.
// - counter mode polarity also sets the initial output level.
// - pwm: toggle output at match; at reload, event, count to 0001.
// - pwm polarity 1: start high, low at match, high at reload.
// - pwm polarity 0: start low, high at match, low at reload.
// - prescaler divides the system clock by 1 up to 128.
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.vh"

module reloadable_timer_core (
   input  wire                clock_i,
   input  wire                arst_n_i,
   input  wire [`ADDR_W-1:0]  addr_i,
   input  wire [`CNT_W-1:0]   wdata_i,
   input  wire                wr_i,
   input  wire                rd_i,
   output reg  [`CNT_W-1:0]   rdata_o,
   input  wire                timer_in_i,
   output reg                 timer_out_o,
   output wire                timer_out_en_o,
   output reg                 event_o
);
   reg                    rst_meta_reg;
   reg                    rst_n_reg;
   reg                    in_meta_reg;
   reg                    in_sync_reg;
   reg                    in_prev_reg;
   reg  [`CTL_W-1:0]      ctl_reg;
   reg  [`CTL_W-1:0]      ctl_next;
   reg  [`CNT_W-1:0]      count_reg;
   reg  [`CNT_W-1:0]      count_next;
   reg  [`CNT_W-1:0]      reload_reg;
   reg  [`CNT_W-1:0]      match_reg;
   reg                    level_reg;
   reg                    level_next;
   reg                    event_flag_reg;
   reg                    event_flag_next;
   reg                    match_flag_reg;
   reg                    match_flag_next;
   reg  [`CNT_W-1:0]      rdata_next;

   wire                   enable;
   wire                   pol;
   wire                   out_en;
   wire [1:0]             mode;
   wire [`PRE_SEL_W-1:0]  pre_sel;
   wire                   pre_tick;
   wire                   in_edge;
   wire                   step;
   wire                   at_reload;
   wire                   at_match;
   wire                   os_flip;
   wire                   wr_ctl;
   wire                   wr_count;
   wire                   wr_reload;
   wire                   wr_match;
   wire                   wr_stat;
   wire [`STAT_W-1:0]     status;

   // reset released through two flops
   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end
   end

   assign enable  = ctl_reg[`CTL_ENABLE_BIT];
   assign pol     = ctl_reg[`CTL_POL_BIT];
   assign out_en  = ctl_reg[`CTL_OUT_EN_BIT];
   assign mode    = ctl_reg[`CTL_MODE_HI:`CTL_MODE_LO];
   assign pre_sel = ctl_reg[`CTL_PRE_HI:`CTL_PRE_LO];
   assign wr_ctl    = wr_i && (addr_i == `ADDR_CONTROL);
   assign wr_count  = wr_i && (addr_i == `ADDR_COUNT);
   assign wr_reload = wr_i && (addr_i == `ADDR_RELOAD);
   assign wr_match  = wr_i && (addr_i == `ADDR_MATCH);
   assign wr_stat   = wr_i && (addr_i == `ADDR_STATUS);

   prescaler u_prescaler (
      .clock_i (clock_i),
      .rst_n_i (rst_n_reg),
      .run_i   (enable && (mode != `MODE_COUNTER)),
      .sel_i   (pre_sel),
      .tick_o  (pre_tick)
   );

   // timer input pin: two flops before any logic reads it; reset low
   // matches the idle pin, so no false edge follows reset
   always @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         in_meta_reg <= 1'b0;
         in_sync_reg <= 1'b0;
      end else begin
         in_meta_reg <= timer_in_i;
         in_sync_reg <= in_meta_reg;
      end
   end

   // history for the edge detector; it reads only the second flop
   always @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         in_prev_reg <= 1'b0;
      end else begin
         in_prev_reg <= in_sync_reg;
      end
   end

   // edges are only caught if the source stays at or below clock/4
   assign in_edge = pol ? (in_sync_reg && !in_prev_reg)
                        : (!in_sync_reg && in_prev_reg);

   assign step = enable && ((mode == `MODE_COUNTER) ? in_edge
                                                    : pre_tick);

   // compare on the step taken while the count sits at the value, so
   // reload 0001 fires every tick and reload 0000 first runs the wrap
   assign at_reload = step && (count_reg == reload_reg);
   assign at_match  = step && (mode == `MODE_PWM)
                      && (count_reg == match_reg);
   assign os_flip   = at_reload && out_en && (mode == `MODE_ONE_SHOT);

   // control register; one-shot clears its own enable at reload
   always @* begin
      ctl_next = ctl_reg;
      if (wr_ctl) begin
         ctl_next = wdata_i[`CTL_W-1:0];
      end else if (at_reload && (mode == `MODE_ONE_SHOT)) begin
         ctl_next[`CTL_ENABLE_BIT] = 1'b0;
      end
   end

   always @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         ctl_reg <= `CTL_RESET;
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   // reload and match are plain storage; pwm needs reload above match
   always @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         reload_reg <= `CNT_ZERO;
      end else if (wr_reload) begin
         reload_reg <= wdata_i;
      end
   end

   always @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         match_reg <= `CNT_ZERO;
      end else if (wr_match) begin
         match_reg <= wdata_i;
      end
   end

   // counter; a count write overrides any step so software can preload
   always @* begin
      count_next = count_reg;
      if (wr_count) begin
         count_next = wdata_i;
      end else if (at_reload) begin
         count_next = `CNT_START;
      end else if (step) begin
         count_next = count_reg + `CNT_ONE;
      end
   end

   always @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         count_reg <= `CNT_ZERO;
      end else begin
         count_reg <= count_next;
      end
   end

   // output level: polarity loaded while the timer is stopped, so a
   // start always begins from the programmed level
   always @* begin
      level_next = level_reg;
      if (!enable) begin
         level_next = wr_ctl ? wdata_i[`CTL_POL_BIT] : pol;
      end else if (mode == `MODE_PWM) begin
         if (at_reload) begin
            level_next = pol;
         end else if (at_match) begin
            level_next = !pol;
         end
      end else if (mode == `MODE_ONE_SHOT) begin
         // follows a polarity flip made after start, for a lasting edge
         level_next = pol;
      end else if (at_reload && out_en) begin
         level_next = !level_reg;
      end
   end

   always @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         level_reg <= 1'b0;
      end else begin
         level_reg <= level_next;
      end
   end

   // one-shot inversion lasts exactly one clock after reload
   always @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         timer_out_o <= 1'b0;
      end else begin
         timer_out_o <= os_flip ? !level_reg : level_reg;
      end
   end

   // interrupt request: one clock after each reload
   always @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         event_o <= 1'b0;
      end else begin
         event_o <= at_reload;
      end
   end

   assign timer_out_en_o = out_en;

   // sticky status flags; a new event wins over a clear in the same cycle
   always @* begin
      event_flag_next = event_flag_reg;
      if (at_reload) begin
         event_flag_next = 1'b1;
      end else if (wr_stat && wdata_i[`STAT_EVENT_BIT]) begin
         event_flag_next = 1'b0;
      end
   end

   always @* begin
      match_flag_next = match_flag_reg;
      if (at_match) begin
         match_flag_next = 1'b1;
      end else if (wr_stat && wdata_i[`STAT_MATCH_BIT]) begin
         match_flag_next = 1'b0;
      end
   end

   always @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         event_flag_reg <= 1'b0;
      end else begin
         event_flag_reg <= event_flag_next;
      end
   end

   always @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         match_flag_reg <= 1'b0;
      end else begin
         match_flag_reg <= match_flag_next;
      end
   end

   // the status word: flags, enable and the output pin level
   assign status = {match_flag_reg, enable,
                    timer_out_o, event_flag_reg};

   // read data stand only in the cycle after the strobe, zero otherwise
   always @* begin
      rdata_next = `CNT_ZERO;
      if (rd_i) begin
         case (addr_i)
            `ADDR_CONTROL: rdata_next = {{(`CNT_W-`CTL_W){1'b0}}, ctl_reg};
            `ADDR_COUNT:   rdata_next = count_reg;
            `ADDR_RELOAD:  rdata_next = reload_reg;
            `ADDR_MATCH:   rdata_next = match_reg;
            `ADDR_STATUS:  rdata_next = {{(`CNT_W-`STAT_W){1'b0}}, status};
            default:       rdata_next = `CNT_ZERO;
         endcase
      end
   end

   always @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         rdata_o <= `CNT_ZERO;
      end else begin
         rdata_o <= rdata_next;
      end
   end
endmodule
`default_nettype wire

/* File: reloadable_timer_core_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.vh"
module reloadable_timer_core_bench;
   logic        clock_i, arst_n_i, wr_i, rd_i, go, busy, pin, out, oe, ev;
   logic [2:0]  addr_i;
   logic [15:0] wdata_i, rdata_o, v;
   logic [7:0]  np;
   integer      err_count, tests_run, seed, cyc, ev_n, ev_t, i, k, e, t, h, p;
   reloadable_timer_core reloadable_timer_core_i (.clock_i(clock_i),
      .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .timer_in_i(pin), .timer_out_o(out),
      .timer_out_en_o(oe), .event_o(ev));
   timer_pins_model timer_pins_model_i (.clock_i(clock_i), .pulses_i(np),
      .go_i(go), .pin_o(pin), .busy_o(busy));
   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (ev === 1'b1) begin
         ev_n <= ev_n + 1;
         ev_t <= cyc;
      end
   end
   task chk(input logic [15:0] s, input logic [15:0] x);
      tests_run = tests_run + 1;
      if (s !== x) begin
         err_count = err_count + 1;
         $display("wrong value at %0t: %h expected %h", $time, s, x);
      end
   endtask
   task wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask
   task rd(input logic [2:0] a);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask
   // disabled while reconfiguring, enabled by the last write
   task cfg(input logic [7:0] c, input logic [15:0] s, r, m);
      wr(0, {8'h00, c & 8'h7f});
      wr(1, s);
      wr(2, r);
      wr(3, m);
      wr(4, 16'h000f);
      wr(0, {8'h00, c});
   endtask
   task wait_ev;
      k = ev_n;
      for (i = 0; i < 3000 && ev_n == k; i = i + 1) begin
         @(posedge clock_i);
         #1;
      end
   endtask
   task pulse(input logic [7:0] n);
      @(posedge clock_i);
      np <= n;
      go <= 1'b1;
      @(posedge clock_i);
      go <= 1'b0;
      #1;
      for (i = 0; i < 500 && busy; i = i + 1) @(posedge clock_i);
      repeat (8) @(posedge clock_i);
      #1;
   endtask
   task conclude;
      if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #(50 * 40000);
      err_count = err_count + 1;
      conclude;
   end
   initial begin
      seed = 32'h0a976c06;
      {err_count, tests_run, cyc, ev_n, ev_t, k} = 0;
      {arst_n_i, wr_i, rd_i, go, addr_i, wdata_i, np} = 0;
      repeat (5) @(posedge clock_i);
      arst_n_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      rd(0); chk(v, 16'h0000);
      wr(7, 16'hffff); rd(7); chk(v, 16'h0000);
      wr(0, 16'h0079); rd(0); chk(v, 16'h0079);
      for (p = 2; p < 4; p = p + 1) begin
         h = $random(seed);
         wr(p[2:0], h[15:0]); rd(p[2:0]); chk(v, h[15:0]);
      end
      for (e = 0; e < 8; e = e + 1) begin
         h = 4 + ($random(seed) & 3);
         cfg(8'ha1 | 8'(e << 2), 16'h0001 + 16'(h - 2), 16'(h), 0);
         wait_ev; wait_ev; t = ev_t; p = out; wait_ev;
         chk(16'(ev_t - t), 16'(h << e));
         chk({15'h0, out}, {15'h0, ~p[0]});
      end
      cfg(8'h81, 16'h0001, 16'h0001, 0); wait_ev; t = ev_t; wait_ev;
      chk(16'(ev_t - t), 16'h0001);
      cfg(8'h81, 16'hfffe, 16'h0002, 0); t = cyc; wait_ev;
      chk({15'h0, ev_t - t >= 4 && ev_t - t <= 8}, 16'h0001);
      for (p = 0; p < 2; p = p + 1) begin
         cfg(8'ha0 | 8'(p << 6), 16'h0001, 16'h0005, 0); k = ev_n; h = 0;
         repeat (40) begin
            @(posedge clock_i);
            #1 if (out !== p[0]) h = h + 1;
         end
         chk(16'(h), 16'h0001);
         chk(16'(ev_n - k), 16'h0001);
         rd(1); chk(v, 16'h0001);
         rd(0); chk(v, 16'h0020 | 16'(p << 6));
         rd(4); chk(v & 16'h0005, 16'h0001);
         wr(4, 16'h0001); rd(4); chk(v & 16'h0001, 16'h0000);
      end
      for (p = 0; p < 2; p = p + 1) begin
         cfg(8'hbe | 8'(p << 6), 16'h0001, 16'h0004, 0); k = ev_n;
         repeat (3) @(posedge clock_i);
         #1 chk({15'h0, out}, {15'h0, p[0]});
         pulse(3); chk(16'(ev_n - k), 16'h0000);
         pulse(1); chk(16'(ev_n - k), 16'h0001);
         chk({15'h0, out}, {15'h0, ~p[0]});
      end
      for (p = 0; p < 2; p = p + 1) begin
         e = 2 + ($random(seed) & 3);
         cfg(8'h83 | 8'(p << 6), 16'h0001, 16'h0007, 16'(e));
         wait_ev; h = 0;
         repeat (6) begin
            @(posedge clock_i);
            #1 h = h + out;
         end
         chk(16'(h), 16'(p ? e - 1 : 7 - e));
      end
      conclude;
   end
endmodule
`default_nettype wire

/* File: reloadable_timer_core_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.vh"
module reloadable_timer_core_sva (
   input wire logic               clock_i,
   input wire logic               arst_n_i,
   input wire logic [`ADDR_W-1:0] addr_i,
   input wire logic [`CNT_W-1:0]  wdata_i,
   input wire logic               wr_i,
   input wire logic               rd_i,
   input wire logic [`CNT_W-1:0]  rdata_o,
   input wire logic               timer_in_i,
   input wire logic               timer_out_o,
   input wire logic               timer_out_en_o,
   input wire logic               event_o
);
   logic [1:0] mode_reg;
   logic       pol_reg;
   wire cw = wr_i && addr_i == `ADDR_CONTROL;
   wire os = mode_reg == `MODE_ONE_SHOT;
   wire pwm = mode_reg == `MODE_PWM;
   wire cnt = mode_reg == `MODE_COUNTER;
   // shadow of mode and polarity; enable is left out since one-shot clears it
   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mode_reg <= 2'h0;
         pol_reg <= 1'b0;
      end else if (cw) begin
         mode_reg <= wdata_i[1:0];
         pol_reg <= wdata_i[6];
      end
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);
   a_rdata_idle: assert property (
      !$past(rd_i) |-> rdata_o == 16'h0000) else $error("rdata not idle");
   a_unmapped_read: assert property (
      rd_i && addr_i > `ADDR_STATUS |=> rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   a_oe_follows: assert property (
      cw |=> timer_out_en_o == $past(wdata_i[5])) else $error("oe wrong");
   a_oe_holds: assert property (
      !cw |=> $stable(timer_out_en_o)) else $error("oe moved");
   a_os_stops: assert property (
      os && event_o |=> !event_o [*8]) else $error("one-shot ran on");
   a_os_cause: assert property (
      os && timer_out_en_o && timer_out_o != pol_reg && !$past(wr_i)
      && !$past(wr_i, 2) |-> ##[0:1] event_o) else $error("stray pulse");
   a_os_restore: assert property (
      os && timer_out_o != pol_reg |-> ##[1:2] timer_out_o == pol_reg)
      else $error("one-shot pulse too long");
   a_pwm_reload: assert property (
      pwm && event_o |=> timer_out_o == pol_reg) else $error("pwm level");
   a_cnt_quiet: assert property (
      (cnt && $stable(timer_in_i)) [*8] |=> !event_o)
      else $error("count without edge");
   c_os: cover property (os && event_o);
   c_pwm: cover property (pwm && event_o);
   c_cnt: cover property (cnt && event_o);
endmodule
bind reloadable_timer_core reloadable_timer_core_sva reloadable_timer_core_sva_i (
   .clock_i(clock_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .timer_in_i(timer_in_i), .timer_out_o(timer_out_o),
   .timer_out_en_o(timer_out_en_o), .event_o(event_o));
`default_nettype wire

/* File: timer_defines.vh */
`ifndef TIMER_DEFINES_VH
`define TIMER_DEFINES_VH

// register addresses on the plain register port
`define ADDR_W            3
`define ADDR_CONTROL      3'h0
`define ADDR_COUNT        3'h1
`define ADDR_RELOAD       3'h2
`define ADDR_MATCH        3'h3
`define ADDR_STATUS       3'h4

// control register fields
`define CTL_W             8
`define CTL_RESET         8'h00
`define CTL_ENABLE_BIT    7
`define CTL_POL_BIT       6
`define CTL_OUT_EN_BIT    5
`define CTL_PRE_HI        4
`define CTL_PRE_LO        2
`define CTL_MODE_HI       1
`define CTL_MODE_LO       0

// mode encodings
`define MODE_ONE_SHOT     2'h0
`define MODE_CONTINUOUS   2'h1
`define MODE_COUNTER      2'h2
`define MODE_PWM          2'h3

// counter values
`define CNT_W             16
`define CNT_ZERO          16'h0000
`define CNT_START         16'h0001
`define CNT_ONE           16'h0001
`define PRE_W             7
`define PRE_ZERO          7'h00
`define PRE_ONE           7'h01
`define PRE_SEL_W         3

// status register bits
`define STAT_W            4
`define STAT_EVENT_BIT    0
`define STAT_OUT_BIT      1
`define STAT_RUN_BIT      2
`define STAT_MATCH_BIT    3

`endif

/* File: timer_pins_model.sv */
`timescale 1ns/1ps
`default_nettype none
// far side of the timer input pin: sends whole pulses on request
module timer_pins_model (
   input  wire logic       clock_i,
   input  wire logic [7:0] pulses_i,
   input  wire logic       go_i,
   output var  logic       pin_o,
   output var  logic       busy_o
);
   integer n;
   initial begin
      pin_o = 1'b0;
      busy_o = 1'b0;
      forever begin
         @(posedge clock_i);
         if (go_i) begin
            busy_o <= 1'b1;
            for (n = 0; n < pulses_i; n = n + 1) begin
               // three clocks per level keeps edges well under a quarter rate
               repeat (3) @(posedge clock_i);
               pin_o <= 1'b1;
               repeat (3) @(posedge clock_i);
               pin_o <= 1'b0;
            end
            busy_o <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire
